// ==== rmsw_pkg.sv ====
/*
 * Package for the reset, mode select and wait block.
 * It holds the timing counts, the status code, the state encoding and the state record.
 * Every count is in processor clocks. One processor clock is two core_clk cycles.
 */
package rmsw_pkg;

    // Processor clocks from the synchronised release to each event, and the wait resample period
    localparam logic [2:0] RMSW_RESET_OUT_CLKS = 3'h2; // reset_out falls
    localparam logic [2:0] RMSW_MODE_CLKS      = 3'h4; // second test/busy sample
    localparam logic [2:0] RMSW_FETCH_CLKS     = 3'h7; // first fetch
    localparam logic [2:0] RMSW_RESAMPLE_CLKS  = 3'h5; // wait gate resample period
    localparam logic [2:0] RMSW_CNT_ZERO       = 3'h0;
    localparam logic [2:0] RMSW_CNT_ONE        = 3'h1;

    // Inactive bus status code driven for one clock on reset entry
    localparam logic [2:0] RMSW_STAT_IDLE      = 3'h7;

    typedef enum logic [4:0] {
        RMSW_ST_RESET   = 5'h01,
        RMSW_ST_RELEASE = 5'h02,
        RMSW_ST_RUN     = 5'h04,
        RMSW_ST_WAIT    = 5'h08,
        RMSW_ST_FPBUSY  = 5'h10
    } rmsw_state_t;

    typedef struct packed {
        logic        clk_div;      // Processor clock phase, drives sys_clock_out
        rmsw_state_t state;
        logic [2:0]  cnt;          // Clock counter for release and wait resampling
        logic        first_sample; // Test/busy seen at the release edge
        logic        enhanced;     // Latched operating mode
        logic        reset_out;
        logic        status_oe;
        logic        fetch_start;
        logic        int_service;
        logic        fp_issue;
    } rmsw_regs_t;

    localparam rmsw_regs_t RMSW_REGS_RESET = '{
        clk_div:      1'b0,
        state:        RMSW_ST_RESET,
        cnt:          3'h0,
        first_sample: 1'b0,
        enhanced:     1'b0,
        reset_out:    1'b1,
        status_oe:    1'b1,
        fetch_start:  1'b0,
        int_service:  1'b0,
        fp_issue:     1'b0
    };

endpackage

// ==== rmsw_sync_if.sv ====
/*
 * Carrier for the init input between the top module and its synchroniser.
 * Assumes the raw side may change at any time relative to core_clk.
 */
`timescale 1ns/10ps
interface rmsw_sync_if;
    logic init_raw_n;
    logic init_sync_n;

    modport sync (input init_raw_n, output init_sync_n);
    modport user (output init_raw_n, input init_sync_n);
endinterface

// ==== rmsw_sync.sv ====
/*
 * Two-flop synchroniser for the asynchronous init input.
 * Assumes core_clk and rst_n as in the top module; resets to the asserted level.
 */
`timescale 1ns/10ps
module rmsw_sync (
    input  wire logic core_clk,
    input  wire logic rst_n,
    rmsw_sync_if.sync sif
);

    typedef struct packed {
        logic meta;
        logic stable;
    } rmsw_sync_regs_t;

    rmsw_sync_regs_t r_q;
    rmsw_sync_regs_t r_d;

    // Only the second flop is read outside; the first may be metastable
    always_comb begin
        r_d.meta   = sif.init_raw_n;
        r_d.stable = r_q.meta;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign sif.init_sync_n = r_q.stable;

endmodule

// ==== rmsw_top.sv ====
/*
 * Reset entry and exit sequencer with operating mode select and the wait/busy gate.
 * core_clk is the oscillator; the processor clock is core_clk divided by two.
 * The execution unit outside raises wait_exec for one cycle when a wait
 * instruction begins and holds fp_cmd_req until fp_cmd_issue answers.
 */
`timescale 1ns/10ps

// How it works
// - Init low aborts everything, clears state, stays dormant until init high.
// - Init input is asynchronous and passes a two-flop synchroniser first.
// - First instruction fetch starts seven clocks after init returns high.
// - On reset entry status lines go inactive one clock, then float.
// - Enhanced mode needs test/busy high at release and low four clocks later.
// - Any other pair of test/busy samples gives compatible mode.
// - Compatible mode: wait instruction with gate high suspends execution.
// - While suspended, gate is resampled every five clocks; low resumes.
// - With interrupts enabled, pending interrupts are serviced during the wait.
// - System clock output has 50% duty; pin timing refers to it.
// - System clock output is the oscillator divided by two.
// - Reset output is high in reset and falls two clocks after release.
// - Reset output wired to test/busy selects enhanced mode.
module rmsw_top (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       external_init_in_n,
    input  wire logic       test_busy_in,
    input  wire logic       wait_exec,
    input  wire logic       fp_cmd_req,
    input  wire logic       int_enabled,
    input  wire logic       int_pending,
    output logic            sys_clock_out,
    output logic            reset_out,
    output logic [2:0]      status_out,
    output logic            status_oe,
    output logic            fetch_start,
    output logic            executing,
    output logic            exec_suspended,
    output logic            int_service,
    output logic            fp_cmd_issue,
    output logic            enhanced_mode
);

    rmsw_pkg::rmsw_regs_t r_q;
    rmsw_pkg::rmsw_regs_t r_d;
    logic                 clk_en;
    logic                 init_n;
    logic                 cnt_last;

    rmsw_sync_if sif ();

    assign sif.init_raw_n = external_init_in_n;

    rmsw_sync u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .sif      (sif)
    );

    assign init_n = sif.init_sync_n;

    // One processor clock per two core_clk cycles, on the rising half
    assign clk_en = ~r_q.clk_div;

    // Resample point inside the wait loop
    assign cnt_last = (r_q.cnt == (rmsw_pkg::RMSW_RESAMPLE_CLKS - rmsw_pkg::RMSW_CNT_ONE));

    always_comb begin
        r_d             = r_q;
        r_d.fetch_start = 1'b0;
        r_d.int_service = 1'b0;
        r_d.fp_issue    = 1'b0;
        r_d.clk_div     = ~r_q.clk_div;

        if (!init_n) begin
            r_d.state        = rmsw_pkg::RMSW_ST_RESET;
            r_d.cnt          = rmsw_pkg::RMSW_CNT_ZERO;
            r_d.reset_out    = 1'b1;
            r_d.first_sample = 1'b0;
            if (r_q.state != rmsw_pkg::RMSW_ST_RESET) begin
                r_d.status_oe = 1'b1;
            end else if (clk_en) begin
                r_d.status_oe = 1'b0;
            end
        end else if (clk_en) begin
            case (r_q.state)
                rmsw_pkg::RMSW_ST_RESET: begin
                    r_d.first_sample = test_busy_in;
                    r_d.status_oe    = 1'b0;
                    r_d.cnt          = rmsw_pkg::RMSW_CNT_ONE;
                    r_d.state        = rmsw_pkg::RMSW_ST_RELEASE;
                end
                rmsw_pkg::RMSW_ST_RELEASE: begin
                    r_d.cnt = 3'(r_q.cnt + rmsw_pkg::RMSW_CNT_ONE);
                    if (r_q.cnt == rmsw_pkg::RMSW_RESET_OUT_CLKS) begin
                        r_d.reset_out = 1'b0;
                    end
                    if (r_q.cnt == rmsw_pkg::RMSW_MODE_CLKS) begin
                        r_d.enhanced = r_q.first_sample & ~test_busy_in;
                    end
                    if (r_q.cnt == rmsw_pkg::RMSW_FETCH_CLKS) begin
                        r_d.fetch_start = 1'b1;
                        r_d.status_oe   = 1'b1;
                        r_d.cnt         = rmsw_pkg::RMSW_CNT_ZERO;
                        r_d.state       = rmsw_pkg::RMSW_ST_RUN;
                    end
                end
                rmsw_pkg::RMSW_ST_RUN: begin
                    if (!r_q.enhanced && wait_exec && test_busy_in) begin
                        r_d.cnt   = rmsw_pkg::RMSW_CNT_ZERO;
                        r_d.state = rmsw_pkg::RMSW_ST_WAIT;
                    end else if (r_q.enhanced && fp_cmd_req) begin
                        if (test_busy_in) begin
                            r_d.state = rmsw_pkg::RMSW_ST_FPBUSY;
                        end else begin
                            r_d.fp_issue = 1'b1;
                        end
                    end
                end
                rmsw_pkg::RMSW_ST_WAIT: begin
                    r_d.int_service = int_enabled & int_pending;
                    if (cnt_last) begin
                        r_d.cnt = rmsw_pkg::RMSW_CNT_ZERO;
                        if (!test_busy_in) begin
                            r_d.state = rmsw_pkg::RMSW_ST_RUN;
                        end
                    end else begin
                        r_d.cnt = 3'(r_q.cnt + rmsw_pkg::RMSW_CNT_ONE);
                    end
                end
                rmsw_pkg::RMSW_ST_FPBUSY: begin
                    if (!test_busy_in) begin
                        r_d.fp_issue = 1'b1;
                        r_d.state    = rmsw_pkg::RMSW_ST_RUN;
                    end
                end
                default: begin
                    r_d.state = rmsw_pkg::RMSW_ST_RESET;
                end
            endcase
        end
        // mode only changes in release phase above
    end

    // Whole block state in one register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            r_q <= rmsw_pkg::RMSW_REGS_RESET;
        end else begin
            r_q <= r_d;
        end
    end

    // Outputs from flops, executing and exec_suspended decoded from state; status value is fixed, only the enable moves
    assign sys_clock_out  = r_q.clk_div;
    assign reset_out      = r_q.reset_out;
    assign status_out     = rmsw_pkg::RMSW_STAT_IDLE;
    assign status_oe      = r_q.status_oe;
    assign fetch_start    = r_q.fetch_start;
    assign int_service    = r_q.int_service;
    assign fp_cmd_issue   = r_q.fp_issue;
    assign enhanced_mode  = r_q.enhanced;
    assign executing      = (r_q.state == rmsw_pkg::RMSW_ST_RUN);
    assign exec_suspended = (r_q.state == rmsw_pkg::RMSW_ST_WAIT)
                          | (r_q.state == rmsw_pkg::RMSW_ST_FPBUSY);

endmodule

// ==== rmsw_top_props.sv ====
/* Checker for the reset, mode select and wait block.
   Sees only the top module ports; all delays are core_clk cycles. */
`timescale 1ns/10ps
module rmsw_top_props (
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       external_init_in_n,
    input wire logic       test_busy_in,
    input wire logic       wait_exec,
    input wire logic       fp_cmd_req,
    input wire logic       int_enabled,
    input wire logic       int_pending,
    input wire logic       sys_clock_out,
    input wire logic       reset_out,
    input wire logic [2:0] status_out,
    input wire logic       status_oe,
    input wire logic       fetch_start,
    input wire logic       executing,
    input wire logic       exec_suspended,
    input wire logic       int_service,
    input wire logic       fp_cmd_issue,
    input wire logic       enhanced_mode
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // Clock output and reset entry
    clk_half_a: assert property (1'b1 |=> sys_clock_out != $past(sys_clock_out))
        else $error("clock output stuck");
    init_abort_a: assert property ($fell(external_init_in_n) |-> ##[2:4] (reset_out && !executing))
        else $error("init not taken");
    status_flt_a: assert property ($rose(reset_out) |->
        (status_oe && status_out == rmsw_pkg::RMSW_STAT_IDLE) ##[1:2] !status_oe)
        else $error("status not floated");
    // Release timing, counted from the rise of init or the fall of reset_out, and the mode hold after release
    rel_time_a: assert property ($rose(external_init_in_n) |-> ##[6:9] $fell(reset_out))
        else $error("reset_out late");
    fetch_gap_a: assert property ($fell(reset_out) |->
        !fetch_start [*8] ##3 fetch_start ##1 !fetch_start)
        else $error("fetch start misplaced");
    mode_pick_a: assert property ($fell(reset_out) |-> ##4
        enhanced_mode == ($past(test_busy_in, 9) && !$past(test_busy_in, 1)))
        else $error("wrong mode");
    mode_hold_a: assert property ($changed(enhanced_mode) |-> !reset_out && !executing)
        else $error("mode changed while running");
    // Wait gate, coprocessor gate and interrupts while waiting
    wait_in_a: assert property (executing && !enhanced_mode && !sys_clock_out && wait_exec
        && test_busy_in |=> exec_suspended)
        else $error("wait not suspended");
    fp_gate_a: assert property (fp_cmd_issue |->
        enhanced_mode && !($past(test_busy_in) && $past(test_busy_in, 2)))
        else $error("command issued while busy");
    int_svc_a: assert property (int_service |->
        $past(exec_suspended) && $past(int_enabled) && $past(int_pending))
        else $error("stray interrupt service");
    cover property (fetch_start && enhanced_mode);
    cover property ($fell(exec_suspended));
    cover property (fp_cmd_issue && $past(test_busy_in, 3));
endmodule

bind rmsw_top rmsw_top_props i_props (.core_clk, .rst_n, .external_init_in_n, .test_busy_in,
    .wait_exec, .fp_cmd_req, .int_enabled, .int_pending, .sys_clock_out, .reset_out,
    .status_out, .status_oe, .fetch_start, .executing, .exec_suspended, .int_service,
    .fp_cmd_issue, .enhanced_mode);

// ==== rmsw_partner.sv ====
/* Far side: reset source on the init pin and coprocessor on test/busy.
   Assumes the bench strobes init_go and sets level_test and loop_rst. */
`timescale 1ns/10ps
module rmsw_partner (
    input  wire logic core_clk,
    input  wire logic init_go,
    input  wire logic level_test,
    input  wire logic loop_rst,
    input  wire logic reset_out,
    input  wire logic fp_cmd_issue,
    output logic      init_n,
    output logic      test_busy
);
    logic [3:0] hold_q = 4'h0;
    logic [3:0] busy_q = 4'h0;
    always @(negedge core_clk) hold_q <= init_go ? 4'hC : hold_q - {3'h0, |hold_q};
    always @(negedge core_clk) busy_q <= fp_cmd_issue ? 4'h9 : busy_q - {3'h0, |busy_q};
    assign init_n    = hold_q == 4'h0;
    assign test_busy = loop_rst ? reset_out : level_test | (|busy_q);
endmodule

// ==== tb_rmsw_top.sv ====
/* Bench for rmsw_top: mode select patterns, wait gate and coprocessor busy.
   Assumes the partner model drives the init and test/busy pins. */
`timescale 1ns/10ps
module tb_rmsw_top;
    logic       core_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       init_go = 1'b0;
    logic       level_test = 1'b1;
    logic       loop_rst = 1'b0;
    logic       wait_exec = 1'b0;
    logic       fp_cmd_req = 1'b0;
    logic       int_enabled = 1'b0;
    logic       int_pending = 1'b0;
    logic       init_n, test_busy, sys_clock_out, reset_out, status_oe, fetch_start;
    logic       executing, exec_suspended, int_service, fp_cmd_issue, enhanced_mode;
    logic [2:0] status_out;
    logic [7:0] susp_n = 8'h00;
    logic [7:0] int_n = 8'h00;
    logic       fp_held = 1'b0;
    logic [7:0] ql[$];
    logic [7:0] qi[$];
    logic       qm[$];
    logic       qf[$];
    logic [2:0] pats[5] = '{3'h0, 3'h2, 3'h4, 3'h6, 3'h1};
    int         error_cnt = 0;
    int         tests_run = 0;
    int         seed = 32'hD504373F;

    always #2 core_clk = ~core_clk;
    rmsw_top i_dut (.core_clk, .rst_n, .external_init_in_n(init_n), .test_busy_in(test_busy),
        .wait_exec, .fp_cmd_req, .int_enabled, .int_pending, .sys_clock_out, .reset_out,
        .status_out, .status_oe, .fetch_start, .executing, .exec_suspended, .int_service,
        .fp_cmd_issue, .enhanced_mode);
    rmsw_partner i_far (.core_clk, .init_go, .level_test, .loop_rst, .reset_out,
        .fp_cmd_issue, .init_n, .test_busy);

    task automatic cmp(input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("Error t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic chk_mode(input logic e, input logic g);
        cmp({7'h0, e}, {7'h0, g});
    endtask
    task automatic chk_len(input logic [7:0] e, input logic [7:0] g);
        cmp(e, g);
    endtask
    task automatic final_report;
        $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Pattern bits: first sample, second sample, reset_out loop
    task automatic do_init(input logic [2:0] p);
        level_test = p[2];
        loop_rst = p[0];
        qm.push_back(p[0] | (p[2] & ~p[1]));
        // Non-blocking, so the partner sees the strobe at one known edge
        init_go <= 1'b1;
        @(negedge core_clk);
        init_go <= 1'b0;
        @(negedge core_clk iff reset_out === 1'b1);
        @(negedge core_clk iff reset_out === 1'b0);
        level_test = p[1];
        @(negedge core_clk iff executing === 1'b1);
        $display("Init pattern %h done", p);
    endtask
    // Gate held high for r extra periods, so the exit lands on a resample
    task automatic do_wait(input logic t, input int r);
        level_test = t;
        {int_enabled, int_pending} = 2'($random(seed));
        wait_exec = 1'b1;
        @(negedge core_clk);
        @(negedge core_clk iff exec_suspended === t);
        wait_exec = 1'b0;
        if (t) begin
            ql.push_back(8'(10 * r + 10));
            qi.push_back((int_enabled & int_pending) ? 8'(5 * r + 5) : 8'h00);
            repeat (10 * r + 3) @(negedge core_clk);
            level_test = 1'b0;
        end
        @(negedge core_clk iff executing === 1'b1);
        $display("Wait test %0d done", r);
    endtask
    // Second command meets the busy left by the first
    task automatic do_fp;
        // Loopback off, or the partner's busy never reaches the pin
        level_test = 1'b0;
        loop_rst = 1'b0;
        qf.push_back(1'b0);
        qf.push_back(1'b1);
        repeat (2) begin
            fp_cmd_req = 1'b1;
            @(negedge core_clk iff fp_cmd_issue === 1'b1);
            fp_cmd_req = 1'b0;
            @(negedge core_clk);
        end
        $display("Coprocessor test done");
    endtask

    // Results are compared in the order they were noted
    always @(negedge core_clk) begin
        if (fetch_start === 1'b1)
            chk_mode(qm.pop_front(), enhanced_mode);
        // Coprocessor hold is tracked apart from the wait gate
        if (exec_suspended === 1'b1 && enhanced_mode === 1'b1)
            fp_held <= 1'b1;
        if (fp_cmd_issue === 1'b1) begin
            chk_mode(qf.pop_front(), fp_held);
            fp_held <= 1'b0;
        end
        // Last interrupt pulse shows on the cycle the wait ends
        if (exec_suspended === 1'b1 && enhanced_mode === 1'b0) begin
            susp_n <= susp_n + 8'h01;
            int_n  <= int_n + {7'h0, int_service};
        end else if (susp_n != 8'h00) begin
            chk_len(ql.pop_front(), susp_n);
            chk_len(qi.pop_front(), int_n + {7'h0, int_service});
            susp_n <= 8'h00;
            int_n  <= 8'h00;
        end
    end
    initial begin
        qm.push_back(1'b0);
        repeat (6) @(negedge core_clk);
        rst_n = 1'b1;
        @(negedge core_clk iff executing === 1'b1);
        foreach (pats[i])
            do_init(pats[i]);
        do_fp;
        do_init(3'h0);
        do_wait(1'b0, 0);
        repeat (3)
            do_wait(1'b1, $unsigned($random(seed)) % 3);
        repeat (4) @(negedge core_clk);
        final_report;
    end
    // Hang guard, far beyond the few hundred cycles needed
    initial begin
        #40000;
        error_cnt++;
        final_report;
    end
endmodule
